// [exec_pkg.sv]
/*
  shared constants, enumerations and carriers for the instruction execute unit.
  assumes an outside decoder presents one decoded instruction at a time, with the
  addressed data byte already read, and an outside data memory that takes write pulses.
*/
package exec_pkg;

  localparam int PC_W = 11; // program counter width
  localparam int STACK_DEPTH = 8; // return stack entries
  localparam int SP_W = 3; // stack pointer width
  localparam logic [PC_W-1:0] PC_RESET = 11'h000; // program counter after reset
  localparam logic [PC_W-1:0] PC_STEP = 11'h001; // sequential advance
  localparam logic [SP_W-1:0] SP_RESET = 3'h0; // stack pointer after reset
  localparam logic [SP_W-1:0] SP_STEP = 3'h1; // push / pop step
  localparam logic [7:0] ACC_RESET = 8'h00; // accumulator after reset
  localparam logic [7:0] BYTE_ZERO = 8'h00; // cleared byte
  localparam logic [7:0] BYTE_ONE = 8'h01; // increment / decrement step
  localparam logic [3:0] BCD_DIGIT_MAX = 4'h9; // largest decimal digit
  localparam logic [8:0] BCD_ADJ_LO = 9'h006; // low digit correction
  localparam logic [8:0] BCD_ADJ_HI = 9'h060; // high digit correction
  localparam int CYCLES_SHORT = 1; // single cycle instruction
  localparam int CYCLES_LONG = 2; // instruction with a dummy cycle
  localparam logic DUMMY_CYCLES = 1'(CYCLES_LONG - CYCLES_SHORT); // stall length

  // decoded operations handled by this unit
  typedef enum logic [4:0] {
    op_idle, op_add_from_ram, op_add_imm, op_sum_to_ram,
    op_add_with_carry, op_add_with_carry_to_ram,
    op_conj_from_ram, op_conj_imm, op_bitwise_conj_to_ram,
    op_disj_from_ram, op_disj_imm, op_bitwise_disj_to_ram,
    op_invert_bits, op_invert_bits_into_register,
    op_plus_one, op_plus_one_into_register,
    op_minus_one, op_minus_one_into_register, op_bcd_fixup,
    op_copy_from_ram, op_copy_imm, op_copy_to_ram,
    op_zero_fill, op_zero_fill_bit,
    op_watchdog_refresh, op_watchdog_refresh_first, op_watchdog_refresh_second,
    op_sleep, op_goto, op_call, op_subroutine_exit, op_subroutine_exit_lit
  } op_e;

  // which paired refresh ran last
  typedef enum logic [1:0] {pre_none, pre_first, pre_second} preclear_e;

  // status flags
  typedef struct packed {
    logic signed_range_error_flag;
    logic zero_flag;
    logic nibble_carry_flag;
    logic carry_flag;
    logic watchdog_expired_flag;
    logic sleep_entered_flag;
  } flags_s;

  localparam flags_s FLAGS_RESET = '0; // all flags clear after reset

  // one decoded instruction
  typedef struct packed {
    op_e op;
    logic [7:0] imm;
    logic [2:0] bit_sel;
    logic [PC_W-1:0] target;
  } instr_s;

  // adder result with its flags
  typedef struct packed {
    logic ovf;
    logic half;
    logic cout;
    logic [7:0] value;
  } sum_s;

endpackage

// [instr_execute.sv]
/*
  execute stage for the arithmetic, logic, move, clear, watchdog, sleep and branch
  instructions of an 8-bit core: accumulator, status flags, program counter and stack.
  assumes the decoder holds instr and mem_rdata stable while instr_valid is high and
  that the data memory writes mem_wdata at its address when mem_we pulses.
*/
module instr_execute
(
  input wire logic sys_clk, // core clock
  input wire logic reset_n, // asynchronous reset, active low
  input wire logic instr_valid, // decoded instruction present
  input wire exec_pkg::instr_s instr, // decoded instruction
  input wire logic [7:0] mem_rdata, // addressed data byte
  input wire logic mem_is_pcl, // addressed byte is program counter low
  input wire logic wdt_timeout, // watchdog expiry pulse
  input wire logic wake_req, // wake request out of sleep
  output logic instr_ready, // unit accepts an instruction
  output logic [7:0] acc, // accumulator
  output exec_pkg::flags_s flags, // status flags
  output logic [exec_pkg::PC_W-1:0] pc, // program counter
  output logic mem_we, // data byte write pulse
  output logic [7:0] mem_wdata, // data byte write value
  output logic wdt_clear, // watchdog and prescaler clear pulse
  output logic sleep_mode // clock stopped, execution halted
);
  import exec_pkg::*;

  // eight bit add with carry in and the overflow, nibble carry and carry flags
  function automatic sum_s add8(input logic [7:0] a, input logic [7:0] b, input logic cin);
    logic [4:0] lo;
    logic [8:0] full;
    sum_s r;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    r.value = full[7:0];
    r.half = lo[4];
    r.cout = full[8];
    r.ovf = (a[7] == b[7]) && (full[7] != a[7]);
    return r;
  endfunction

  // zero test on an eight bit result
  function automatic logic is_zero(input logic [7:0] v);
    return v == BYTE_ZERO;
  endfunction

  // architectural state
  logic [7:0] acc_reg, acc_next; // accumulator
  flags_s flags_reg, flags_next; // status flags
  logic [PC_W-1:0] pc_reg, pc_next; // program counter
  logic [SP_W-1:0] sp_reg, sp_next; // stack pointer, next free entry
  logic [PC_W-1:0] stack_mem [STACK_DEPTH]; // return addresses
  logic busy_reg, busy_next; // dummy cycle in progress
  logic sleep_reg, sleep_next; // sleeping
  preclear_e preclear_reg, preclear_next; // last paired refresh seen
  logic mem_we_reg, mem_we_next; // write pulse
  logic [7:0] mem_wdata_reg, mem_wdata_next; // write data
  logic wdt_clear_reg, wdt_clear_next; // watchdog clear pulse

  // results of the decode
  logic [7:0] res; // eight bit result
  logic wr_acc; // result goes to accumulator
  logic wr_mem; // result goes to data byte
  flags_s ex_flags; // flags after execution
  logic pc_load; // load pc from target
  logic push; // push return address
  logic pop; // pop return address
  logic wdt_clr; // clear the watchdog
  logic sleep_go; // enter sleep
  logic long_op; // needs a dummy cycle
  preclear_e pre_n; // next pairing state

  // shared operand selection
  wire go = instr_valid && instr_ready; // instruction taken this edge
  wire imm_src = instr.op inside {op_add_imm, op_conj_imm, op_disj_imm}; // immediate operand
  wire with_carry = instr.op inside {op_add_with_carry, op_add_with_carry_to_ram}; // carry in
  wire [7:0] operand = imm_src ? instr.imm : mem_rdata; // second operand
  wire sum_s sum = add8(acc_reg, operand, with_carry && flags_reg.carry_flag);
  wire [7:0] conj = acc_reg & operand; // bitwise and
  wire [7:0] disj = acc_reg | operand; // bitwise or
  wire [7:0] inv = ~mem_rdata; // ones complement
  wire [7:0] inc = mem_rdata + BYTE_ONE; // increment
  wire [7:0] dec = mem_rdata - BYTE_ONE; // decrement
  wire [7:0] bit_cleared = mem_rdata & ~(BYTE_ONE << instr.bit_sel);
  wire [PC_W-1:0] pc_plus = pc_reg + PC_STEP; // next sequential address
  wire [SP_W-1:0] sp_top = sp_reg - SP_STEP; // last pushed entry

  // decimal adjust: the high test looks at the digit after the low correction, so a
  // carry out of the low digit is not lost
  wire lo_adj = (acc_reg[3:0] > BCD_DIGIT_MAX) || flags_reg.nibble_carry_flag;
  wire [8:0] bcd_mid = {1'b0, acc_reg} + (lo_adj ? BCD_ADJ_LO : 9'h000);
  wire hi_adj = (bcd_mid[7:4] > BCD_DIGIT_MAX) || flags_reg.carry_flag || bcd_mid[8];
  wire [8:0] bcd_out = bcd_mid + (hi_adj ? BCD_ADJ_HI : 9'h000);

  // a memory destination that is program counter low lands in the pc, not in memory
  wire pcl_wr = wr_mem && mem_is_pcl;

  // instruction decode and execution
  always_comb
  begin
    res = acc_reg;
    wr_acc = 1'b0;
    wr_mem = 1'b0;
    ex_flags = flags_reg;
    pc_load = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    wdt_clr = 1'b0;
    sleep_go = 1'b0;
    long_op = 1'b0;
    pre_n = preclear_reg;
    case (instr.op)
      op_add_from_ram, op_add_imm, op_add_with_carry, op_sum_to_ram,
      op_add_with_carry_to_ram:
      begin
        res = sum.value;
        wr_acc = !(instr.op inside {op_sum_to_ram, op_add_with_carry_to_ram});
        wr_mem = !wr_acc;
        ex_flags.signed_range_error_flag = sum.ovf;
        ex_flags.nibble_carry_flag = sum.half;
        ex_flags.carry_flag = sum.cout;
        ex_flags.zero_flag = is_zero(sum.value);
      end
      op_conj_from_ram, op_conj_imm, op_bitwise_conj_to_ram:
      begin
        res = conj;
        wr_acc = instr.op != op_bitwise_conj_to_ram;
        wr_mem = !wr_acc;
        ex_flags.zero_flag = is_zero(conj);
      end
      op_disj_from_ram, op_disj_imm, op_bitwise_disj_to_ram:
      begin
        res = disj;
        wr_acc = instr.op != op_bitwise_disj_to_ram;
        wr_mem = !wr_acc;
        ex_flags.zero_flag = is_zero(disj);
      end
      op_invert_bits, op_invert_bits_into_register:
      begin
        res = inv;
        wr_acc = instr.op == op_invert_bits_into_register;
        wr_mem = !wr_acc;
        ex_flags.zero_flag = is_zero(inv);
      end
      op_plus_one, op_plus_one_into_register:
      begin
        res = inc;
        wr_acc = instr.op == op_plus_one_into_register;
        wr_mem = !wr_acc;
        ex_flags.zero_flag = is_zero(inc);
      end
      op_minus_one, op_minus_one_into_register:
      begin
        res = dec;
        wr_acc = instr.op == op_minus_one_into_register;
        wr_mem = !wr_acc;
        ex_flags.zero_flag = is_zero(dec);
      end
      op_bcd_fixup:
      begin
        res = bcd_out[7:0];
        wr_mem = 1'b1;
        ex_flags.carry_flag = flags_reg.carry_flag || hi_adj;
      end
      op_copy_from_ram:
      begin
        res = mem_rdata;
        wr_acc = 1'b1;
      end
      op_copy_imm:
      begin
        res = instr.imm;
        wr_acc = 1'b1;
      end
      op_copy_to_ram:
      begin
        res = acc_reg;
        wr_mem = 1'b1;
      end
      op_zero_fill:
      begin
        res = BYTE_ZERO;
        wr_mem = 1'b1;
      end
      op_zero_fill_bit:
      begin
        res = bit_cleared;
        wr_mem = 1'b1;
      end
      op_watchdog_refresh:
      begin
        wdt_clr = 1'b1;
        pre_n = pre_none;
      end
      op_watchdog_refresh_first, op_watchdog_refresh_second:
      begin
        // only the second half of an alternating pair clears anything
        if (preclear_reg == (instr.op == op_watchdog_refresh_first ? pre_second : pre_first))
        begin
          wdt_clr = 1'b1;
          pre_n = pre_none;
        end
        else
        begin
          pre_n = instr.op == op_watchdog_refresh_first ? pre_first : pre_second;
        end
      end
      op_sleep:
      begin
        sleep_go = 1'b1;
      end
      op_goto:
      begin
        pc_load = 1'b1;
        long_op = 1'b1;
      end
      op_call:
      begin
        pc_load = 1'b1;
        push = 1'b1;
        long_op = 1'b1;
      end
      op_subroutine_exit, op_subroutine_exit_lit:
      begin
        pop = 1'b1;
        long_op = 1'b1;
        res = instr.imm;
        wr_acc = instr.op == op_subroutine_exit_lit;
      end
      op_idle:
      begin
        res = acc_reg;
      end
      default:
      begin
        res = acc_reg;
      end
    endcase
    if (wdt_clr)
    begin
      ex_flags.watchdog_expired_flag = 1'b0;
      ex_flags.sleep_entered_flag = 1'b0;
    end
    if (sleep_go)
    begin
      ex_flags.watchdog_expired_flag = 1'b0;
      ex_flags.sleep_entered_flag = 1'b1;
    end
  end

  // next state; a watchdog expiry in the same cycle as a clear still sets the flag
  always_comb
  begin
    acc_next = (go && wr_acc) ? res : acc_reg;
    flags_next = go ? ex_flags : flags_reg;
    flags_next.watchdog_expired_flag = flags_next.watchdog_expired_flag || wdt_timeout;
    if (!go)
      pc_next = pc_reg;
    else if (pop)
      pc_next = stack_mem[sp_top];
    else if (pc_load)
      pc_next = instr.target;
    else if (pcl_wr)
      pc_next = {pc_plus[PC_W-1:8], res};
    else
      pc_next = pc_plus;
    sp_next = (go && push) ? sp_reg + SP_STEP : (go && pop) ? sp_top : sp_reg;
    busy_next = go && (long_op || pcl_wr) ? DUMMY_CYCLES : 1'b0;
    sleep_next = (go && sleep_go) || (sleep_reg && !wake_req);
    preclear_next = go ? pre_n : preclear_reg;
    mem_we_next = go && wr_mem && !mem_is_pcl;
    mem_wdata_next = (go && wr_mem) ? res : mem_wdata_reg;
    wdt_clear_next = go && (wdt_clr || sleep_go);
  end

  // state registers
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      acc_reg <= ACC_RESET;
      flags_reg <= FLAGS_RESET;
      pc_reg <= PC_RESET;
      sp_reg <= SP_RESET;
      busy_reg <= 1'b0;
      sleep_reg <= 1'b0;
      preclear_reg <= pre_none;
      mem_we_reg <= 1'b0;
      mem_wdata_reg <= BYTE_ZERO;
      wdt_clear_reg <= 1'b0;
    end
    else
    begin
      acc_reg <= acc_next;
      flags_reg <= flags_next;
      pc_reg <= pc_next;
      sp_reg <= sp_next;
      busy_reg <= busy_next;
      sleep_reg <= sleep_next;
      preclear_reg <= preclear_next;
      mem_we_reg <= mem_we_next;
      mem_wdata_reg <= mem_wdata_next;
      wdt_clear_reg <= wdt_clear_next;
    end
  end

  // return stack; contents need no reset, the pointer guards them and it wraps when full
  always_ff @(posedge sys_clk)
  begin
    if (go && push)
      stack_mem[sp_reg] <= pc_plus;
  end

  // outputs
  assign instr_ready = !busy_reg && !sleep_reg;
  assign acc = acc_reg;
  assign flags = flags_reg;
  assign pc = pc_reg;
  assign mem_we = mem_we_reg;
  assign mem_wdata = mem_wdata_reg;
  assign wdt_clear = wdt_clear_reg;
  assign sleep_mode = sleep_reg;

  property p_adc_acc;
    @(posedge sys_clk) disable iff (!reset_n)
    go && instr.op == op_add_with_carry |=>
      acc_reg == 8'($past(acc_reg) + $past(mem_rdata) + {7'h00, $past(flags_reg.carry_flag)});
  endproperty
  a_adc_acc: assert property (p_adc_acc) else $error("add with carry wrong");

  property p_adc_ram;
    @(posedge sys_clk) disable iff (!reset_n)
    go && instr.op == op_add_with_carry_to_ram && !mem_is_pcl |=> mem_we &&
      mem_wdata == 8'($past(acc_reg) + $past(mem_rdata) + {7'h00, $past(flags_reg.carry_flag)});
  endproperty
  a_adc_ram: assert property (p_adc_ram) else $error("add with carry to byte wrong");

  property p_conj_flags;
    @(posedge sys_clk) disable iff (!reset_n)
    go && instr.op == op_conj_from_ram |=> acc_reg == ($past(acc_reg) & $past(mem_rdata)) &&
      flags_reg.carry_flag == $past(flags_reg.carry_flag) && flags_reg.zero_flag == (acc_reg == 8'h00);
  endproperty
  a_conj_flags: assert property (p_conj_flags) else $error("and result or flags wrong");

  property p_call;
    @(posedge sys_clk) disable iff (!reset_n)
    go && instr.op == op_call |=> pc_reg == $past(instr.target) && !instr_ready &&
      $stable(flags_reg.carry_flag) ##1 instr_ready;
  endproperty
  a_call: assert property (p_call) else $error("call timing or target wrong");

  property p_zero_fill;
    @(posedge sys_clk) disable iff (!reset_n)
    go && instr.op == op_zero_fill && !mem_is_pcl |=> mem_we && mem_wdata == 8'h00 &&
      flags_reg.zero_flag == $past(flags_reg.zero_flag);
  endproperty
  a_zero_fill: assert property (p_zero_fill) else $error("byte clear wrong");

  property p_preclear_repeat;
    @(posedge sys_clk) disable iff (!reset_n)
    go && instr.op == op_watchdog_refresh_first && preclear_reg == pre_first |=> !wdt_clear;
  endproperty
  a_preclear_repeat: assert property (p_preclear_repeat) else $error("repeated preclear acted");

  property p_sleep;
    @(posedge sys_clk) disable iff (!reset_n)
    go && instr.op == op_sleep && !wdt_timeout |=> sleep_mode && wdt_clear &&
      flags_reg.sleep_entered_flag && !flags_reg.watchdog_expired_flag && !instr_ready;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep entry wrong");

  property p_goto;
    @(posedge sys_clk) disable iff (!reset_n)
    go && instr.op == op_goto |=> pc_reg == $past(instr.target) && !instr_ready ##1 $stable(pc_reg);
  endproperty
  a_goto: assert property (p_goto) else $error("jump wrong");

  property p_inc_reg;
    @(posedge sys_clk) disable iff (!reset_n)
    go && instr.op == op_plus_one_into_register |=> !mem_we &&
      acc_reg == 8'($past(mem_rdata) + 8'h01) && flags_reg.zero_flag == ($past(mem_rdata) == 8'hff);
  endproperty
  a_inc_reg: assert property (p_inc_reg) else $error("increment into accumulator wrong");

endmodule // instr_execute

// [data_store.sv]
/*
  far-side model: sixteen bytes of data memory and a watchdog counter.
  assumes the bench holds addr through each instruction; writes arrive as one-cycle pulses.
*/
module data_store
#(
  parameter int WDT_LIMIT = 400 // cycles without a clear before expiry
)
(
  input wire logic sys_clk, // core clock
  input wire logic reset_n, // asynchronous reset, active low
  input wire logic [3:0] addr, // byte address from the bench
  input wire logic mem_we, // write pulse from the unit
  input wire logic [7:0] mem_wdata, // write value
  input wire logic wdt_clear, // watchdog clear pulse
  output logic [7:0] mem_rdata, // addressed byte
  output logic wdt_timeout // one-cycle expiry pulse
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [16]; // byte store
  logic [9:0] wdt_count; // cycles since last clear

  // preset contents that the scenarios read back
  initial mem = '{8'h00, 8'h80, 8'h05, 8'h7A, 8'h05, 8'h5A, 8'hFF, 8'h0F,
                  8'hFF, 8'h55, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  assign mem_rdata = mem[addr]; // asynchronous read, like a register file
  assign wdt_timeout = (wdt_count == 10'(WDT_LIMIT)); // fires once per pass

  // the write lands at the edge after the pulse, with the address still held
  always @(posedge sys_clk)
  begin
    if (mem_we)
    begin
      mem[addr] <= mem_wdata;
    end
  end

  // counter restarts on every clear; it wraps, so a long run expires again
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wdt_count <= 10'h000;
    end
    else
    begin
      wdt_count <= wdt_clear ? 10'h000 : wdt_count + 10'h001;
    end
  end
endmodule // data_store

// [testbench.sv]
/*
  self-checking bench for the execute unit: one task issues a decoded instruction
  and compares accumulator, flags and write port; scenarios are lists of such calls.
  assumes the data_store model on the far side and a 250 MHz core clock.
*/
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import exec_pkg::*;

  logic sys_clk, reset_n, instr_valid, mem_is_pcl, wake_req; // driven inputs
  instr_s instr; // instruction being offered
  logic [3:0] addr; // data byte address
  logic [7:0] mem_rdata, acc, mem_wdata; // data paths
  flags_s flags; // status flags
  logic [PC_W-1:0] pc; // program counter
  logic instr_ready, mem_we, wdt_clear, sleep_mode, wdt_timeout; // unit status
  int fail_count = 0; // mismatches seen
  int compares = 0; // comparisons made

  instr_execute instr_execute_i (.sys_clk(sys_clk), .reset_n(reset_n),
    .instr_valid(instr_valid), .instr(instr), .mem_rdata(mem_rdata),
    .mem_is_pcl(mem_is_pcl), .wdt_timeout(wdt_timeout), .wake_req(wake_req),
    .instr_ready(instr_ready), .acc(acc), .flags(flags), .pc(pc), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .wdt_clear(wdt_clear), .sleep_mode(sleep_mode));

  data_store data_store_i (.sys_clk(sys_clk), .reset_n(reset_n), .addr(addr),
    .mem_we(mem_we), .mem_wdata(mem_wdata), .wdt_clear(wdt_clear),
    .mem_rdata(mem_rdata), .wdt_timeout(wdt_timeout));

  // 4 ns period
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // verdict and end of run, reached from the main sequence and from every bound
  task automatic test_done();
    if (fail_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // four-state compare; an unknown never matches
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // offer one instruction, wait for it to be taken, then compare the answer cycle;
  // flags are {range error, zero, nibble carry, carry, expired, sleep}
  task automatic step(op_e op, logic [7:0] imm, logic [3:0] a, logic [7:0] ea,
                      logic [5:0] ef, logic ew, logic [7:0] ed);
    int n;
    n = 0;
    @(posedge sys_clk);
    instr_valid <= 1'b1;
    instr <= '{op: op, imm: imm, bit_sel: imm[2:0], target: {3'h0, imm}};
    addr <= a;
    #1;
    // a dummy cycle or sleep refuses the offer; the offer is held meanwhile
    while (instr_ready !== 1'b1)
    begin
      if (n++ > 20)
      begin
        fail_count++;
        test_done();
      end
      @(posedge sys_clk);
      #1;
    end
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    #1;
    check("acc", {8'h00, acc}, {8'h00, ea});
    check("flags", {10'h000, flags}, {10'h000, ef});
    check("mem_we", {15'h0000, mem_we}, {15'h0000, ew});
    if (ew)
      check("mem_wdata", {8'h00, mem_wdata}, {8'h00, ed});
  endtask

  // a branch target wider than the immediate field
  task automatic branch(op_e op, logic [PC_W-1:0] t, logic [PC_W-1:0] epc);
    @(posedge sys_clk);
    instr_valid <= 1'b1;
    instr <= '{op: op, imm: 8'h3C, bit_sel: 3'h0, target: t};
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    #1;
    check("pc", {5'h00, pc}, {5'h00, epc});
    check("instr_ready", {15'h0000, instr_ready}, 16'h0000);
  endtask

  // bounded wait for the far side to expire the watchdog
  task automatic wait_expired();
    int n;
    n = 0;
    while (flags.watchdog_expired_flag !== 1'b1)
    begin
      if (n++ > 1000)
      begin
        fail_count++;
        test_done();
      end
      @(posedge sys_clk);
      #1;
    end
  endtask

  // main sequence
  initial
  begin
    reset_n = 1'b0;
    instr_valid = 1'b0;
    instr = '0;
    addr = 4'h0;
    mem_is_pcl = 1'b0;
    wake_req = 1'b0;
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    #1;
    check("pc", {5'h00, pc}, 16'h0000);
    check("sleep_mode", {15'h0000, sleep_mode}, 16'h0000);
    // arithmetic with flag generation
    step(op_copy_imm, 8'h7F, 4'h0, 8'h7F, 6'h00, 1'b0, 8'h00);
    step(op_add_imm, 8'h01, 4'h0, 8'h80, 6'h28, 1'b0, 8'h00);
    step(op_sum_to_ram, 8'h00, 4'h1, 8'h80, 6'h34, 1'b1, 8'h00);
    step(op_add_with_carry, 8'h00, 4'h2, 8'h86, 6'h00, 1'b0, 8'h00);
    step(op_add_with_carry_to_ram, 8'h00, 4'h3, 8'h86, 6'h1C, 1'b1, 8'h00);
    step(op_copy_imm, 8'h99, 4'h0, 8'h99, 6'h1C, 1'b0, 8'h00);
    step(op_add_imm, 8'h99, 4'h0, 8'h32, 6'h2C, 1'b0, 8'h00);
    step(op_bcd_fixup, 8'h00, 4'h0, 8'h32, 6'h2C, 1'b1, 8'h98);
    // logic operations touch only the zero flag
    step(op_conj_imm, 8'h0F, 4'h0, 8'h02, 6'h2C, 1'b0, 8'h00);
    step(op_conj_from_ram, 8'h00, 4'h1, 8'h00, 6'h3C, 1'b0, 8'h00);
    step(op_disj_imm, 8'hA0, 4'h0, 8'hA0, 6'h2C, 1'b0, 8'h00);
    step(op_disj_from_ram, 8'h00, 4'h4, 8'hA5, 6'h2C, 1'b0, 8'h00);
    step(op_bitwise_conj_to_ram, 8'h00, 4'h5, 8'hA5, 6'h3C, 1'b1, 8'h00);
    step(op_bitwise_disj_to_ram, 8'h00, 4'h4, 8'hA5, 6'h2C, 1'b1, 8'hA5);
    step(op_invert_bits, 8'h00, 4'h6, 8'hA5, 6'h3C, 1'b1, 8'h00);
    step(op_invert_bits_into_register, 8'h00, 4'h7, 8'hF0, 6'h2C, 1'b0, 8'h00);
    step(op_plus_one_into_register, 8'h00, 4'h8, 8'h00, 6'h3C, 1'b0, 8'h00);
    step(op_plus_one, 8'h00, 4'h8, 8'h00, 6'h3C, 1'b1, 8'h00);
    step(op_minus_one, 8'h00, 4'h8, 8'h00, 6'h2C, 1'b1, 8'hFF);
    step(op_minus_one_into_register, 8'h00, 4'h8, 8'hFE, 6'h2C, 1'b0, 8'h00);
    // clears and moves keep every flag
    step(op_zero_fill, 8'h00, 4'h9, 8'hFE, 6'h2C, 1'b1, 8'h00);
    step(op_zero_fill_bit, 8'h03, 4'hA, 8'hFE, 6'h2C, 1'b1, 8'hF7);
    step(op_copy_from_ram, 8'h00, 4'hA, 8'hF7, 6'h2C, 1'b0, 8'h00);
    step(op_copy_to_ram, 8'h00, 4'hB, 8'hF7, 6'h2C, 1'b1, 8'hF7);
    step(op_idle, 8'h00, 4'h0, 8'hF7, 6'h2C, 1'b0, 8'h00);
    // branches take a dummy cycle
    branch(op_goto, 11'h123, 11'h123);
    branch(op_call, 11'h200, 11'h200);
    step(op_idle, 8'h00, 4'h0, 8'hF7, 6'h2C, 1'b0, 8'h00);
    check("pc", {5'h00, pc}, 16'h0201);
    step(op_subroutine_exit_lit, 8'h3C, 4'h0, 8'h3C, 6'h2C, 1'b0, 8'h00);
    check("pc", {5'h00, pc}, 16'h0124);
    branch(op_call, 11'h300, 11'h300);
    branch(op_subroutine_exit, 11'h000, 11'h125);
    // a write to the program counter low byte redirects the pc
    @(posedge sys_clk);
    mem_is_pcl <= 1'b1;
    step(op_zero_fill, 8'h00, 4'h0, 8'h3C, 6'h2C, 1'b0, 8'h00);
    check("pc", {5'h00, pc}, 16'h0100);
    check("instr_ready", {15'h0000, instr_ready}, 16'h0000);
    @(posedge sys_clk);
    mem_is_pcl <= 1'b0;
    // watchdog refresh, single and paired
    wait_expired();
    step(op_watchdog_refresh, 8'h00, 4'h0, 8'h3C, 6'h2C, 1'b0, 8'h00);
    check("wdt_clear", {15'h0000, wdt_clear}, 16'h0001);
    wait_expired();
    step(op_watchdog_refresh_first, 8'h00, 4'h0, 8'h3C, 6'h2E, 1'b0, 8'h00);
    step(op_idle, 8'h00, 4'h0, 8'h3C, 6'h2E, 1'b0, 8'h00);
    step(op_watchdog_refresh_first, 8'h00, 4'h0, 8'h3C, 6'h2E, 1'b0, 8'h00);
    step(op_watchdog_refresh_second, 8'h00, 4'h0, 8'h3C, 6'h2C, 1'b0, 8'h00);
    check("wdt_clear", {15'h0000, wdt_clear}, 16'h0001);
    // sleep holds until woken, keeps the accumulator
    step(op_sleep, 8'h00, 4'h0, 8'h3C, 6'h2D, 1'b0, 8'h00);
    check("wdt_clear", {15'h0000, wdt_clear}, 16'h0001);
    repeat (3) @(posedge sys_clk);
    #1;
    check("sleep_mode", {15'h0000, sleep_mode}, 16'h0001);
    check("instr_ready", {15'h0000, instr_ready}, 16'h0000);
    @(posedge sys_clk);
    wake_req <= 1'b1;
    @(posedge sys_clk);
    @(posedge sys_clk);
    wake_req <= 1'b0;
    #1;
    check("sleep_mode", {15'h0000, sleep_mode}, 16'h0000);
    step(op_watchdog_refresh, 8'h00, 4'h0, 8'h3C, 6'h2C, 1'b0, 8'h00);
    // decimal adjust must raise carry by itself when carry starts clear
    step(op_add_imm, 8'h00, 4'h0, 8'h3C, 6'h00, 1'b0, 8'h00);
    step(op_copy_imm, 8'hA0, 4'h0, 8'hA0, 6'h00, 1'b0, 8'h00);
    step(op_bcd_fixup, 8'h00, 4'hC, 8'hA0, 6'h04, 1'b1, 8'h00);
    test_done();
  end
endmodule // testbench
